// ==== inc/tdm_map.svh ====
`ifndef TDM_MAP_SVH
`define TDM_MAP_SVH

// register offsets
`define TDM_OFS_TOUCH_CFG      7'h05
`define TDM_OFS_TEMP_UPPER     7'h06
`define TDM_OFS_TEMP_LOWER     7'h07
`define TDM_OFS_AUX_ONE_UPPER  7'h08
`define TDM_OFS_AUX_ONE_LOWER  7'h09
`define TDM_OFS_AUX_TWO_UPPER  7'h0A
`define TDM_OFS_AUX_TWO_LOWER  7'h0B

// touch config fields
`define TDM_CFG_PEN_DIS_BIT    6
`define TDM_CFG_PRE_MSB        5
`define TDM_CFG_PRE_LSB        3
`define TDM_CFG_SENSE_MSB      2
`define TDM_CFG_SENSE_LSB      0
`define TDM_CFG_RW_MASK        16'h007F

// limit register fields
`define TDM_LIM_EN_BIT         12
`define TDM_LIM_MSB            11
`define TDM_LIM_RW_MASK        16'h1FFF

// reset values
`define TDM_RST_TOUCH_CFG      16'h0000
`define TDM_RST_UPPER_LIMIT    12'hFFF
`define TDM_RST_LOWER_LIMIT    12'h000

// converter mode code that selects the second temperature channel (non-auto-scan)
`define TDM_SCAN_MODE_TEMP_CHANNEL_SECOND    4'hB

// clock rate and interval times in ns
`define TDM_CLK_MHZ            25
`define TDM_PRE_NS_0           20000
`define TDM_PRE_NS_1           84000
`define TDM_PRE_NS_2           276000
`define TDM_PRE_NS_3           340000
`define TDM_PRE_NS_4           1044000
`define TDM_PRE_NS_5           1108000
`define TDM_PRE_NS_6           1300000
`define TDM_PRE_NS_7           1364000
`define TDM_SENSE_NS_0         32000
`define TDM_SENSE_NS_1         96000
`define TDM_SENSE_NS_2         544000
`define TDM_SENSE_NS_3         608000
`define TDM_SENSE_NS_4         2080000
`define TDM_SENSE_NS_5         2144000
`define TDM_SENSE_NS_6         2592000
`define TDM_SENSE_NS_7         2656000

// least time rounded up to whole cycles
`define TDM_NS_TO_CYC(ns)      (((ns) * `TDM_CLK_MHZ + 999) / 1000)

`endif

// ==== inc/tdm_pkg.sv ====
package tdm_pkg;

  // converter channels
  typedef enum logic [1:0] {
    TDM_CH_TEMP_CHANNEL_FIRST,
    TDM_CH_TEMP_CHANNEL_SECOND,
    TDM_CH_AUX_INPUT_ONE,
    TDM_CH_AUX_INPUT_TWO
  } tdm_chan_t;

  // one converted result
  typedef struct packed {
    logic        valid;
    tdm_chan_t   chan;
    logic [11:0] code;
  } tdm_conv_t;

  // register access from the serial port decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } tdm_reg_req_t;

endpackage

// ==== design/tdm_limit_check.sv ====
`timescale 1ns/1ps
module tdm_limit_check #(
  parameter bit UPPER  = 1'b1,
  parameter int CODE_W = 12
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // measurement and limit
  input  wire logic              sample,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic [CODE_W-1:0] limit,
  input  wire logic              en,
  // results
  output logic                   flag_reg,
  output logic                   hit_reg
);

  logic flag_next;

  // crossing compare, inclusive of the limit
  // at-or-beyond compare
  always_comb begin
    flag_next = UPPER ? (code >= limit) : (code <= limit);
  end

  // flag follows every new sample of its channel
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (sample) begin
      flag_reg <= flag_next;
    end
  end

  // hit only from an enabled check
  // enable gates hit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= sample & en & flag_next;
    end
  end

  hit_needs_en_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    hit_reg |-> $past(en) && $past(sample))
    else $error("limit hit without enabled sample");

  flag_tracks_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    sample |=> flag_reg == (UPPER ? ($past(code) >= $past(limit)) : ($past(code) <= $past(limit))))
    else $error("limit flag does not match compare");

endmodule

// ==== design/tdm_top.sv ====
`timescale 1ns/1ps
`include "tdm_map.svh"

module tdm_top #(
  parameter int CNT_W       = 17,
  parameter int PRE_CYC_2   = `TDM_NS_TO_CYC(`TDM_PRE_NS_2),
  parameter int PRE_CYC_3   = `TDM_NS_TO_CYC(`TDM_PRE_NS_3),
  parameter int PRE_CYC_4   = `TDM_NS_TO_CYC(`TDM_PRE_NS_4),
  parameter int PRE_CYC_5   = `TDM_NS_TO_CYC(`TDM_PRE_NS_5),
  parameter int PRE_CYC_6   = `TDM_NS_TO_CYC(`TDM_PRE_NS_6),
  parameter int PRE_CYC_7   = `TDM_NS_TO_CYC(`TDM_PRE_NS_7),
  parameter int SENSE_CYC_2 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_2),
  parameter int SENSE_CYC_3 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_3),
  parameter int SENSE_CYC_4 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_4),
  parameter int SENSE_CYC_5 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_5),
  parameter int SENSE_CYC_6 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_6),
  parameter int SENSE_CYC_7 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_7)
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // register access
  input  wire tdm_pkg::tdm_reg_req_t reg_req,
  output logic [15:0]               reg_rdata_reg,
  output logic                      reg_rvalid_reg,
  // converter results and scan context
  input  wire tdm_pkg::tdm_conv_t   conv,
  input  wire logic                 auto_scan,
  input  wire logic                 temp_source_select,
  input  wire logic [3:0]           converter_scan_mode,
  // panel
  input  wire logic                 pen_sense_pin,
  output logic                      precharge_drv_reg,
  output logic                      sense_en_reg,
  output logic                      pen_touched_reg,
  // limit results
  output logic [5:0]                limit_flags,
  output logic                      limit_irq_reg
);
  import tdm_pkg::*;

  localparam int NCHK        = 6;
  localparam int PRE_CYC_0   = `TDM_NS_TO_CYC(`TDM_PRE_NS_0);
  localparam int PRE_CYC_1   = `TDM_NS_TO_CYC(`TDM_PRE_NS_1);
  localparam int SENSE_CYC_0 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_0);
  localparam int SENSE_CYC_1 = `TDM_NS_TO_CYC(`TDM_SENSE_NS_1);

  typedef enum logic [1:0] {
    TDM_ST_IDLE,
    TDM_ST_PRECHARGE,
    TDM_ST_SENSE
  } tdm_state_t;

  // register state
  logic [15:0]     touch_cfg_reg;
  logic [11:0]     limit_reg [NCHK];
  logic [NCHK-1:0] check_en_reg;
  // sequencer state
  tdm_state_t      state_reg;
  tdm_state_t      state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic            pen_meta_reg;
  logic            pen_sync_reg;
  // compare results
  logic [NCHK-1:0] sample;
  logic [NCHK-1:0] hit;
  tdm_chan_t       temp_chan;

  // config fields
  logic       pen_detect_disable;
  logic [2:0] precharge_interval_sel;
  logic [2:0] sense_interval_sel;

  assign pen_detect_disable     = touch_cfg_reg[`TDM_CFG_PEN_DIS_BIT];
  assign precharge_interval_sel = touch_cfg_reg[`TDM_CFG_PRE_MSB:`TDM_CFG_PRE_LSB];
  assign sense_interval_sel     = touch_cfg_reg[`TDM_CFG_SENSE_MSB:`TDM_CFG_SENSE_LSB];

  // limit register index, or -1 when not a limit register
  function automatic int lim_index(input logic [6:0] addr);
    if (addr >= `TDM_OFS_TEMP_UPPER && addr <= `TDM_OFS_AUX_TWO_LOWER) begin
      return int'(addr - `TDM_OFS_TEMP_UPPER);
    end
    return -1;
  endfunction

  // precharge count minus one for a code
  function automatic logic [CNT_W-1:0] pre_load(input logic [2:0] sel);
    int c;
    c = PRE_CYC_0;
    unique case (sel)
      3'h0: c = PRE_CYC_0;
      3'h1: c = PRE_CYC_1;
      3'h2: c = PRE_CYC_2;
      3'h3: c = PRE_CYC_3;
      3'h4: c = PRE_CYC_4;
      3'h5: c = PRE_CYC_5;
      3'h6: c = PRE_CYC_6;
      3'h7: c = PRE_CYC_7;
    endcase
    return CNT_W'(c - 1);
  endfunction

  // sense count minus one for a code
  function automatic logic [CNT_W-1:0] sense_load(input logic [2:0] sel);
    int c;
    c = SENSE_CYC_0;
    unique case (sel)
      3'h0: c = SENSE_CYC_0;
      3'h1: c = SENSE_CYC_1;
      3'h2: c = SENSE_CYC_2;
      3'h3: c = SENSE_CYC_3;
      3'h4: c = SENSE_CYC_4;
      3'h5: c = SENSE_CYC_5;
      3'h6: c = SENSE_CYC_6;
      3'h7: c = SENSE_CYC_7;
    endcase
    return CNT_W'(c - 1);
  endfunction

  // touch config write, reserved bits dropped
  // reserved bits masked
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      touch_cfg_reg <= `TDM_RST_TOUCH_CFG;
    end else if (reg_req.wr && reg_req.addr == `TDM_OFS_TOUCH_CFG) begin
      touch_cfg_reg <= reg_req.wdata & `TDM_CFG_RW_MASK;
    end
  end

  // limit and enable registers, even index upper, odd lower
  // enables reset off
  genvar gi;
  generate
    for (gi = 0; gi < NCHK; gi++) begin : g_lim
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          limit_reg[gi]    <= (gi % 2 == 0) ? `TDM_RST_UPPER_LIMIT : `TDM_RST_LOWER_LIMIT;
          check_en_reg[gi] <= 1'b0;
        end else if (reg_req.wr && lim_index(reg_req.addr) == gi) begin
          limit_reg[gi]    <= reg_req.wdata[`TDM_LIM_MSB:0];
          check_en_reg[gi] <= reg_req.wdata[`TDM_LIM_EN_BIT];
        end
      end
    end
  endgenerate

  // read data, unmapped and reserved bits as zero
  // reserved reads zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_reg  <= 16'h0000;
      reg_rvalid_reg <= 1'b0;
    end else begin
      reg_rvalid_reg <= reg_req.rd;
      if (reg_req.rd) begin
        if (reg_req.addr == `TDM_OFS_TOUCH_CFG) begin
          reg_rdata_reg <= touch_cfg_reg;
        end else if (lim_index(reg_req.addr) >= 0) begin
          reg_rdata_reg <= {3'h0, check_en_reg[lim_index(reg_req.addr)], limit_reg[lim_index(reg_req.addr)]};
        end else begin
          reg_rdata_reg <= 16'h0000;
        end
      end
    end
  end

  // pen pin synchroniser
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pen_meta_reg <= 1'b0;
      pen_sync_reg <= 1'b0;
    end else begin
      pen_meta_reg <= pen_sense_pin;
      pen_sync_reg <= pen_meta_reg;
    end
  end

  // touch detect sequencer next state
  // disable forces idle
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (pen_detect_disable) begin
      state_next = TDM_ST_IDLE;
      cnt_next   = '0;
    end else begin
      unique case (state_reg)
        TDM_ST_IDLE: begin
          state_next = TDM_ST_PRECHARGE;
          cnt_next   = pre_load(precharge_interval_sel);
        end
        TDM_ST_PRECHARGE: begin
          if (cnt_reg == '0) begin
            state_next = TDM_ST_SENSE;
            cnt_next   = sense_load(sense_interval_sel);
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        TDM_ST_SENSE: begin
          if (cnt_reg == '0) begin
            state_next = TDM_ST_PRECHARGE;
            cnt_next   = pre_load(precharge_interval_sel);
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // sequencer state and counter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= TDM_ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // panel drive outputs and touch result
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      precharge_drv_reg <= 1'b0;
      sense_en_reg      <= 1'b0;
      pen_touched_reg   <= 1'b0;
    end else begin
      precharge_drv_reg <= (state_next == TDM_ST_PRECHARGE);
      sense_en_reg      <= (state_next == TDM_ST_SENSE);
      if (pen_detect_disable) begin
        pen_touched_reg <= 1'b0;
      end else if (state_reg == TDM_ST_SENSE && cnt_reg == '0) begin
        pen_touched_reg <= pen_sync_reg;
      end
    end
  end

  // temperature channel in use
  // channel choice
  always_comb begin
    if (auto_scan) begin
      temp_chan = temp_source_select ? TDM_CH_TEMP_CHANNEL_SECOND : TDM_CH_TEMP_CHANNEL_FIRST;
    end else begin
      temp_chan = (converter_scan_mode == `TDM_SCAN_MODE_TEMP_CHANNEL_SECOND) ? TDM_CH_TEMP_CHANNEL_SECOND : TDM_CH_TEMP_CHANNEL_FIRST;
    end
  end

  // per-check sampling and compare
  // both scan kinds
  generate
    for (gi = 0; gi < NCHK; gi++) begin : g_chk
      tdm_chan_t want;
      assign want       = (gi < 2) ? temp_chan : ((gi < 4) ? TDM_CH_AUX_INPUT_ONE : TDM_CH_AUX_INPUT_TWO);
      assign sample[gi] = conv.valid && (conv.chan == want);
      tdm_limit_check #(
        .UPPER  (gi % 2 == 0),
        .CODE_W (12)
      ) u_chk (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .sample   (sample[gi]),
        .code     (conv.code),
        .limit    (limit_reg[gi]),
        .en       (check_en_reg[gi]),
        .flag_reg (limit_flags[gi]),
        .hit_reg  (hit[gi])
      );
    end
  endgenerate

  // combined limit interrupt
  // only enabled hits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      limit_irq_reg <= 1'b0;
    end else begin
      limit_irq_reg <= |hit;
    end
  end
  pen_disable_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    pen_detect_disable |=> !precharge_drv_reg && !sense_en_reg && !pen_touched_reg)
    else $error("pen detect active while disabled");
  sense_after_pre_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sense_en_reg) |-> $past(precharge_drv_reg))
    else $error("sense began without precharge");
  pre_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_reg == TDM_ST_PRECHARGE && $past(state_reg) != TDM_ST_PRECHARGE)
      |-> cnt_reg == pre_load($past(precharge_interval_sel)))
    else $error("precharge count wrong");
  sense_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_reg == TDM_ST_SENSE && $past(state_reg) != TDM_ST_SENSE)
      |-> cnt_reg == sense_load($past(sense_interval_sel)))
    else $error("sense count wrong");
  temp_upper_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sample[0] && check_en_reg[0] && conv.code >= limit_reg[0]) |-> ##2 limit_irq_reg)
    else $error("temperature upper crossing missed");
  temp_lower_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sample[1] && check_en_reg[1] && conv.code <= limit_reg[1]) |-> ##2 limit_irq_reg)
    else $error("temperature lower crossing missed");
  irq_needs_en_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    limit_irq_reg |-> |($past(sample, 2) & $past(check_en_reg, 2)))
    else $error("interrupt from disabled check");
  temp_chan_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (conv.valid && auto_scan && conv.chan == TDM_CH_TEMP_CHANNEL_SECOND) |-> sample[0] == temp_source_select)
    else $error("wrong temperature channel checked");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rvalid_reg |-> reg_rdata_reg[15:13] == 3'h0 && ($past(reg_req.addr) != `TDM_OFS_TOUCH_CFG
      || reg_rdata_reg[15:7] == 9'h000))
    else $error("reserved read bits not zero");
endmodule

// ==== dv/tdm_panel_model.sv ====
`timescale 1ns/1ps
module tdm_panel_model (
  // clock
  input  wire logic          sys_clk,
  // panel drive from the device, touch request from the bench
  input  wire logic          precharge_drv,
  input  wire logic          sense_en,
  input  wire logic          touch_req,
  // panel line and converter result
  output logic               pen_sense_pin,
  output tdm_pkg::tdm_conv_t conv
);
  import tdm_pkg::*;

  // line is pulled low unless a touch closes it while sensing
  assign pen_sense_pin = touch_req & sense_en & ~precharge_drv;

  // converter idles with no strobe
  initial begin
    conv = '0;
  end

  // one result strobe, then the code is turned over so stale data never matches
  task automatic send(input tdm_chan_t ch, input logic [11:0] code);
    @(posedge sys_clk) #1;
    conv = '{1'b1, ch, code};
    @(posedge sys_clk) #1;
    conv = '{1'b0, ch, ~code};
  endtask
endmodule

// ==== dv/touch_detect_threshold_monitor_bench.sv ====
`timescale 1ns/1ps
`include "tdm_map.svh"
module touch_detect_threshold_monitor_bench;
  import tdm_pkg::*;
  localparam int PRE[8]   = '{500, 2100, 12, 13, 14, 15, 16, 17};
  localparam int SENSE[8] = '{800, 2400, 22, 23, 24, 25, 26, 27};
  logic         sys_clk;
  logic         resetn;
  tdm_reg_req_t req;
  logic [15:0]  rdata;
  logic         rvalid;
  tdm_conv_t    conv;
  logic         auto_scan;
  logic         src_sel;
  logic [3:0]   scan_mode;
  logic         pen_pin;
  logic         pre_drv;
  logic         sense_en;
  logic         pen_touched;
  logic         touched;
  logic [5:0]   flags;
  logic         irq;
  int           n_errors = 0;
  int           tests_run = 0;

  // device with short intervals for the long codes
  tdm_top #(
    .PRE_CYC_2(PRE[2]), .PRE_CYC_3(PRE[3]), .PRE_CYC_4(PRE[4]), .PRE_CYC_5(PRE[5]),
    .PRE_CYC_6(PRE[6]), .PRE_CYC_7(PRE[7]), .SENSE_CYC_2(SENSE[2]), .SENSE_CYC_3(SENSE[3]),
    .SENSE_CYC_4(SENSE[4]), .SENSE_CYC_5(SENSE[5]), .SENSE_CYC_6(SENSE[6]), .SENSE_CYC_7(SENSE[7])
  ) uut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_req(req), .reg_rdata_reg(rdata),
    .reg_rvalid_reg(rvalid), .conv(conv), .auto_scan(auto_scan), .temp_source_select(src_sel),
    .converter_scan_mode(scan_mode), .pen_sense_pin(pen_pin), .precharge_drv_reg(pre_drv),
    .sense_en_reg(sense_en), .pen_touched_reg(pen_touched), .limit_flags(flags), .limit_irq_reg(irq)
  );

  // panel and converter on the far side
  tdm_panel_model pm (
    .sys_clk(sys_clk), .precharge_drv(pre_drv), .sense_en(sense_en),
    .touch_req(touched), .pen_sense_pin(pen_pin), .conv(conv)
  );

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] rst_val(input int a);
    return (a == 6 || a == 8 || a == 10) ? 16'h0FFF : 16'h0000;
  endfunction

  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk) #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) #1;
    req = '0;
  endtask

  task automatic reg_rd(input logic [6:0] a, output logic [15:0] d);
    int n;
    @(posedge sys_clk) #1;
    req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk) #1;
    req = '0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge sys_clk) #1;
      n++;
    end
    check(16'(n), 16'h0000);
    d = rdata;
  endtask

  // cycles a panel output keeps the given level
  task automatic span(input bit s, input logic lvl, output int n);
    n = 0;
    while ((s ? sense_en : pre_drv) === lvl && n < 10000) begin
      @(posedge sys_clk) #1;
      n++;
    end
    check(16'(n >= 10000), 16'h0000);
  endtask

  // one result, then irq pulses counted over four cycles
  task automatic conv_chk(input tdm_chan_t ch, input logic [11:0] code, input int i,
                          input logic ef, input int ei);
    int cnt;
    cnt = 0;
    pm.send(ch, code);
    repeat (4) begin
      if (irq === 1'b1) cnt++;
      @(posedge sys_clk) #1;
    end
    check(flags[i], ef);
    check(16'(cnt), 16'(ei));
  endtask

  // reset values, reserved bits and an unmapped offset
  task automatic t_regs;
    logic [15:0] d;
    for (int a = 5; a <= 12; a++) begin
      reg_rd(a[6:0], d);
      check(d, rst_val(a));
      reg_wr(a[6:0], 16'hFFFF);
      reg_rd(a[6:0], d);
      check(d, a == 5 ? 16'h007F : a == 12 ? 16'h0000 : 16'h1FFF);
      reg_wr(a[6:0], rst_val(a));
    end
  endtask

  // every precharge and sense code, sense only after precharge
  task automatic t_intervals;
    int n;
    for (int k = 0; k < 8; k++) begin
      reg_wr(`TDM_OFS_TOUCH_CFG, 16'(k * 8 + 7 - k));
      span(1'b0, 1'b1, n);
      span(1'b0, 1'b0, n);
      check(sense_en, 1'b0);
      span(1'b0, 1'b1, n);
      check(16'(n), 16'(PRE[k]));
      check(sense_en, 1'b1);
      span(1'b1, 1'b1, n);
      check(16'(n), 16'(SENSE[7 - k]));
    end
  endtask

  // touch result, then detection switched off and back on
  task automatic t_pen;
    int n;
    reg_wr(`TDM_OFS_TOUCH_CFG, 16'h0012);
    for (int j = 0; j < 3; j++) begin
      touched = j != 1;
      repeat (2) begin
        span(1'b1, 1'b0, n);
        span(1'b1, 1'b1, n);
      end
      check(pen_touched, touched);
    end
    reg_wr(`TDM_OFS_TOUCH_CFG, 16'h0052);
    @(posedge sys_clk) #1;
    repeat (40) begin
      check({pre_drv, sense_en, pen_touched}, 3'b000);
      @(posedge sys_clk) #1;
    end
    reg_wr(`TDM_OFS_TOUCH_CFG, 16'h0012);
    span(1'b0, 1'b0, n);
    check(pre_drv, 1'b1);
    touched = 1'b0;
  endtask

  // each check at its boundary, just inside, and disabled
  task automatic t_limits;
    tdm_chan_t ch;
    for (int i = 0; i < 6; i++) begin
      ch = tdm_chan_t'(i < 2 ? 0 : i / 2 + 1);
      reg_wr(7'(6 + i), 16'h1400);
      conv_chk(ch, 12'h400, i, 1'b1, 1);
      conv_chk(ch, i % 2 ? 12'h401 : 12'h3FF, i, 1'b0, 0);
      reg_wr(7'(6 + i), 16'h0400);
      conv_chk(ch, 12'h400, i, 1'b1, 0);
      reg_wr(7'(6 + i), rst_val(6 + i));
    end
  endtask

  // temperature channel chosen by source bit or mode field
  task automatic t_temp_sel;
    // bits: auto, source, mode[3:0], second channel, irq expected
    logic [7:0] rows[7] = '{8'hC3, 8'hC0, 8'hAD, 8'h6F, 8'h2C, 8'h41, 8'h42};
    for (int r = 0; r < 7; r++) begin
      if (r == 0) reg_wr(`TDM_OFS_TEMP_UPPER, 16'h1400);
      auto_scan = rows[r][7];
      src_sel = rows[r][6];
      scan_mode = rows[r][5:2];
      conv_chk(tdm_chan_t'(rows[r][1]), 12'h500, 0, 1'b1, rows[r][0]);
    end
    reg_wr(`TDM_OFS_TEMP_UPPER, 16'h0FFF);
  endtask

  // main sequence
  initial begin
    req = '0;
    auto_scan = 1'b0;
    src_sel = 1'b0;
    scan_mode = 4'h0;
    touched = 1'b0;
    resetn = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1'b1;
    t_regs();
    t_intervals();
    t_pen();
    t_limits();
    t_temp_sel();
    finish_test();
  end

  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule
